// file: hdl/fhdr_descriptor_rom.sv
// Full-speed hub descriptor byte source with a valid/ready/last stream
`timescale 1ns/1ps

module fhdr_descriptor_rom (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic fs_mode_in,
    input wire logic string_en_in,
    input wire logic multi_tt_in,
    input wire logic self_power_select_in,
    input wire logic ids_loaded_in,
    input wire logic [15:0] cfg_vendor_id_in,
    input wire logic [15:0] cfg_product_id_in,
    input wire logic [15:0] cfg_device_id_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_sel_in,
    input wire logic [7:0] req_len_in,
    output logic req_ready_out,
    output logic byte_valid_out,
    output logic [7:0] byte_data_out,
    output logic byte_last_out,
    input wire logic byte_ready_in
);
    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    fhdr_pkg::fhdr_state_t state_r;
    fhdr_pkg::fhdr_sel_t sel_r;
    logic [7:0] idx_r;
    logic [7:0] limit_r;
    logic [7:0] rom_byte;
    logic [7:0] desc_len;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] did;
    logic [7:0] s_man;
    logic [7:0] s_prod;
    logic [7:0] s_ser;
    logic [7:0] qual_proto;
    logic [7:0] req_limit;
    logic advance;
    logic sending_r;
    logic last_r;
    logic advance_pending_r;

    // -----------------------------------------------------------
    // Field lookup
    // -----------------------------------------------------------
    // Configured field values
    assign vid = ids_loaded_in ? cfg_vendor_id_in : fhdr_pkg::DEF_VENDOR_ID;
    assign pid = ids_loaded_in ? cfg_product_id_in : fhdr_pkg::DEF_PRODUCT_ID;
    assign did = ids_loaded_in ? cfg_device_id_in : fhdr_pkg::DEF_DEVICE_ID;
    assign s_man = string_en_in ? fhdr_pkg::STR_MANUF : fhdr_pkg::STR_NONE;
    assign s_prod = string_en_in ? fhdr_pkg::STR_PRODUCT : fhdr_pkg::STR_NONE;
    assign s_ser = string_en_in ? fhdr_pkg::STR_SERIAL : fhdr_pkg::STR_NONE;
    assign qual_proto = multi_tt_in ? fhdr_pkg::PROTO_MULTI_TT : fhdr_pkg::PROTO_SINGLE_TT;

    // Descriptor byte lookup, low byte of each word first
    always_comb begin
        rom_byte = 8'h00;
        desc_len = 8'h00;
        case (sel_r)
            fhdr_pkg::FHDR_SEL_DEVICE: begin
                desc_len = fhdr_pkg::DEV_LEN;
                case (idx_r)
                    8'h00: rom_byte = fhdr_pkg::DEV_LEN;
                    8'h01: rom_byte = fhdr_pkg::DEV_TYPE;
                    8'h02: rom_byte = fhdr_pkg::USB_REL[7:0];
                    8'h03: rom_byte = fhdr_pkg::USB_REL[15:8];
                    8'h04: rom_byte = fhdr_pkg::HUB_CLASS;
                    8'h05: rom_byte = fhdr_pkg::HUB_SUBCLASS;
                    8'h06: rom_byte = fhdr_pkg::DEV_PROTOCOL;
                    8'h07: rom_byte = fhdr_pkg::EP0_MAXPKT;
                    8'h08: rom_byte = vid[7:0];
                    8'h09: rom_byte = vid[15:8];
                    8'h0A: rom_byte = pid[7:0];
                    8'h0B: rom_byte = pid[15:8];
                    8'h0C: rom_byte = did[7:0];
                    8'h0D: rom_byte = did[15:8];
                    8'h0E: rom_byte = s_man;
                    8'h0F: rom_byte = s_prod;
                    8'h10: rom_byte = s_ser;
                    8'h11: rom_byte = fhdr_pkg::NUM_CONFIGS;
                    default: rom_byte = 8'h00;
                endcase
            end
            fhdr_pkg::FHDR_SEL_QUALIFIER: begin
                desc_len = fhdr_pkg::QUAL_LEN;
                case (idx_r)
                    8'h00: rom_byte = fhdr_pkg::QUAL_LEN;
                    8'h01: rom_byte = fhdr_pkg::QUAL_TYPE;
                    8'h02: rom_byte = fhdr_pkg::USB_REL[7:0];
                    8'h03: rom_byte = fhdr_pkg::USB_REL[15:8];
                    8'h04: rom_byte = fhdr_pkg::HUB_CLASS;
                    8'h05: rom_byte = fhdr_pkg::HUB_SUBCLASS;
                    8'h06: rom_byte = qual_proto;
                    8'h07: rom_byte = fhdr_pkg::EP0_MAXPKT;
                    8'h08: rom_byte = fhdr_pkg::NUM_CONFIGS;
                    8'h09: rom_byte = fhdr_pkg::QUAL_RESERVED;
                    default: rom_byte = 8'h00;
                endcase
            end
            fhdr_pkg::FHDR_SEL_ENDPOINT: begin
                desc_len = fhdr_pkg::EP_LEN;
                case (idx_r)
                    8'h00: rom_byte = fhdr_pkg::EP_LEN;
                    8'h01: rom_byte = fhdr_pkg::EP_TYPE;
                    8'h02: rom_byte = fhdr_pkg::EP_ADDR;
                    8'h03: rom_byte = fhdr_pkg::EP_ATTR;
                    8'h04: rom_byte = fhdr_pkg::EP_MAXPKT[7:0];
                    8'h05: rom_byte = fhdr_pkg::EP_MAXPKT[15:8];
                    8'h06: rom_byte = fhdr_pkg::EP_INTERVAL;
                    default: rom_byte = 8'h00;
                endcase
            end
            default: begin
                desc_len = fhdr_pkg::CFG_ATTR_LEN;
                rom_byte = self_power_select_in ? fhdr_pkg::CFG_ATTR_SELF : fhdr_pkg::CFG_ATTR_BUS;
            end
        endcase
    end

    // Host may ask for fewer bytes than the descriptor holds; zero means all
    always_comb begin
        req_limit = req_len_in;
        if (req_len_in == 8'h00) begin
            req_limit = 8'hFF;
        end
    end

    // Only accept requests while idle and in full-speed enumeration
    assign req_ready_out = (state_r == fhdr_pkg::FHDR_ST_IDLE) && fs_mode_in;
    // Only a beat actually handed over moves the index; a bare ready must not skip a byte
    assign advance = (state_r == fhdr_pkg::FHDR_ST_SEND) && byte_valid_out && byte_ready_in;

    // -----------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_r <= fhdr_pkg::FHDR_ST_IDLE;
            sel_r <= fhdr_pkg::FHDR_SEL_DEVICE;
            idx_r <= 8'h00;
            limit_r <= 8'h00;
        end else begin
            case (state_r)
                fhdr_pkg::FHDR_ST_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        state_r <= fhdr_pkg::FHDR_ST_SEND;
                        sel_r <= fhdr_pkg::fhdr_sel_t'(req_sel_in);
                        idx_r <= 8'h00;
                        limit_r <= req_limit;
                    end
                end
                fhdr_pkg::FHDR_ST_SEND: begin
                    // Offset order, one byte per accepted beat
                    if (advance) begin
                        if (byte_last_out) begin
                            state_r <= fhdr_pkg::FHDR_ST_DONE;
                        end
                        idx_r <= idx_r + 8'h01;
                    end
                end
                fhdr_pkg::FHDR_ST_DONE: begin
                    state_r <= fhdr_pkg::FHDR_ST_IDLE;
                end
                default: begin
                    state_r <= fhdr_pkg::FHDR_ST_IDLE;
                end
            endcase
        end
    end

    // Data outputs registered from the lookup; refreshed every cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            byte_data_out <= 8'h00;
        end else begin
            byte_data_out <= rom_byte;
        end
    end

    // -----------------------------------------------------------
    // Output stage
    // -----------------------------------------------------------
    // Valid follows the sequencer one cycle late so it lines up with the data flop
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sending_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            sending_r <= (state_r == fhdr_pkg::FHDR_ST_SEND) && !(advance && byte_last_out);
            last_r <= ((idx_r + 8'h01) >= desc_len) || ((idx_r + 8'h01) >= limit_r);
        end
    end

    // Stall advance until the data flop holds the current index
    assign byte_valid_out = sending_r && (state_r == fhdr_pkg::FHDR_ST_SEND) && !advance_pending_r;
    assign byte_last_out = byte_valid_out && last_r;

    // A beat taken moves idx; the next byte is ready two cycles after that beat, after one idle cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            advance_pending_r <= 1'b0;
        end else begin
            advance_pending_r <= advance && byte_valid_out;
        end
    end
endmodule : fhdr_descriptor_rom

// file: hdl/fhdr_pkg.sv
// Constants for the full-speed hub descriptor source
package fhdr_pkg;
    // Descriptor selectors
    typedef enum logic [1:0] {
        FHDR_SEL_DEVICE = 2'b00,
        FHDR_SEL_QUALIFIER = 2'b01,
        FHDR_SEL_ENDPOINT = 2'b10,
        FHDR_SEL_CONFIG_ATTR = 2'b11
    } fhdr_sel_t;

    // Request/answer states
    typedef enum logic [1:0] {
        FHDR_ST_IDLE = 2'b00,
        FHDR_ST_SEND = 2'b01,
        FHDR_ST_DONE = 2'b10
    } fhdr_state_t;

    // Endpoint descriptor fields
    localparam logic [7:0] EP_LEN = 8'h07;
    localparam logic [7:0] EP_TYPE = 8'h05;
    localparam logic [7:0] EP_ADDR = 8'h81;
    localparam logic [7:0] EP_ATTR = 8'h03;
    localparam logic [15:0] EP_MAXPKT = 16'h0001;
    localparam logic [7:0] EP_INTERVAL = 8'hFF;

    // Device descriptor fields
    localparam logic [7:0] DEV_LEN = 8'h12;
    localparam logic [7:0] DEV_TYPE = 8'h01;
    localparam logic [15:0] USB_REL = 16'h0200;
    localparam logic [7:0] HUB_CLASS = 8'h09;
    localparam logic [7:0] HUB_SUBCLASS = 8'h00;
    localparam logic [7:0] DEV_PROTOCOL = 8'h00;
    localparam logic [7:0] EP0_MAXPKT = 8'h40;
    localparam logic [7:0] NUM_CONFIGS = 8'h01;
    localparam logic [7:0] STR_NONE = 8'h00;
    localparam logic [7:0] STR_MANUF = 8'h01;
    localparam logic [7:0] STR_PRODUCT = 8'h02;
    localparam logic [7:0] STR_SERIAL = 8'h03;

    // Qualifier descriptor fields
    localparam logic [7:0] QUAL_LEN = 8'h0A;
    localparam logic [7:0] QUAL_TYPE = 8'h06;
    localparam logic [7:0] PROTO_SINGLE_TT = 8'h01;
    localparam logic [7:0] PROTO_MULTI_TT = 8'h02;
    localparam logic [7:0] QUAL_RESERVED = 8'h00;

    // Configuration attribute byte
    localparam logic [7:0] CFG_ATTR_BUS = 8'hA0;
    localparam logic [7:0] CFG_ATTR_SELF = 8'hE0;
    localparam logic [7:0] CFG_ATTR_LEN = 8'h01;

    // Built-in ID defaults; values arbitrary
    localparam logic [15:0] DEF_VENDOR_ID = 16'h1234;
    localparam logic [15:0] DEF_PRODUCT_ID = 16'h5678;
    localparam logic [15:0] DEF_DEVICE_ID = 16'h0100;
endpackage : fhdr_pkg

// file: verification/fhdr_descriptor_rom_properties.sv
// Concurrent checks on the hub descriptor source ports
`timescale 1ns/1ps
module fhdr_descriptor_rom_properties (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic fs_mode_in,
    input wire logic self_power_select_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_sel_in,
    input wire logic req_ready_out,
    input wire logic byte_valid_out,
    input wire logic [7:0] byte_data_out,
    input wire logic byte_last_out,
    input wire logic byte_ready_in
);
    // ----------------------------------------
    // Handshake and first-byte checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence took(logic [1:0] s);
        req_valid_in && req_ready_out && req_sel_in == s;
    endsequence
    sequence gap_then_byte;
        !byte_valid_out ##1 byte_valid_out;
    endsequence
    chk_ready_needs_fs: assert property (req_ready_out |-> fs_mode_in)
        else $error("ready outside full-speed mode");
    chk_answer_latency: assert property (req_valid_in && req_ready_out |=> gap_then_byte)
        else $error("first byte not two cycles after request");
    chk_byte_holds: assert property (byte_valid_out && !byte_ready_in |=>
        byte_valid_out && $stable(byte_data_out) && $stable(byte_last_out))
        else $error("byte changed before acceptance");
    chk_gap_after_accept: assert property (byte_valid_out && byte_ready_in |=> !byte_valid_out)
        else $error("no idle cycle after accepted byte");
    chk_busy_refuses: assert property (byte_valid_out |-> !req_ready_out)
        else $error("request taken while busy");
    chk_done_refuses: assert property (byte_valid_out && byte_ready_in && byte_last_out |=> !req_ready_out)
        else $error("request taken right after last byte");
    chk_endpoint_len: assert property (took(2'h2) |-> ##2 byte_data_out == 8'h07)
        else $error("endpoint length byte wrong");
    chk_device_len: assert property (took(2'h0) |-> ##2 byte_data_out == 8'h12)
        else $error("device length byte wrong");
    chk_qual_len: assert property (took(2'h1) |-> ##2 byte_data_out == 8'h0A)
        else $error("qualifier length byte wrong");
    chk_attr_power: assert property (took(2'h3) |-> ##2 byte_last_out &&
        byte_data_out == (self_power_select_in ? 8'hE0 : 8'hA0))
        else $error("attribute byte wrong");
endmodule : fhdr_descriptor_rom_properties

bind fhdr_descriptor_rom fhdr_descriptor_rom_properties chk_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .fs_mode_in(fs_mode_in), .self_power_select_in(self_power_select_in), .req_valid_in(req_valid_in),
    .req_sel_in(req_sel_in), .req_ready_out(req_ready_out), .byte_valid_out(byte_valid_out),
    .byte_data_out(byte_data_out), .byte_last_out(byte_last_out), .byte_ready_in(byte_ready_in));

// file: verification/fhdr_host_model.sv
// Upstream host model: descriptor byte sink that can stall
`timescale 1ns/1ps
module fhdr_host_model (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_data_in,
    input wire logic byte_last_in,
    output logic byte_ready_out
);
    logic [7:0] rx_q[$];
    logic [1:0] wait_r;
    // Byte count at the most recent beat flagged last
    int last_seen;
    // Stall holds ready low two cycles per byte, so holding is exercised
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wait_r <= 2'h0;
            byte_ready_out <= 1'b0;
            last_seen <= 0;
        end else if (byte_valid_in && byte_ready_out) begin
            rx_q.push_back(byte_data_in);
            if (byte_last_in) begin
                last_seen <= rx_q.size();
            end
            wait_r <= 2'h0;
            byte_ready_out <= !stall_in;
        end else begin
            wait_r <= byte_valid_in ? wait_r + 2'h1 : 2'h0;
            byte_ready_out <= !stall_in || wait_r == 2'h1;
        end
    end
endmodule : fhdr_host_model

// file: verification/tb_top.sv
// Self-checking bench for the hub descriptor source
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic fs = 1'b1, str = 1'b0, mtt = 1'b0, spw = 1'b0, ldd = 1'b0, rv = 1'b0, stall = 1'b0;
    logic rdy, bv, bl, br;
    logic [15:0] vid = 16'hA1B2, pid = 16'hC3D4, did = 16'hE5F6;
    logic [1:0] sel = 2'h0;
    logic [7:0] len = 8'h00, bd;
    logic [7:0] exp_q[$];
    int n_fail = 0, total_checks = 0, cycles = 0;
    fhdr_descriptor_rom fhdr_descriptor_rom_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .fs_mode_in(fs),
        .string_en_in(str), .multi_tt_in(mtt), .self_power_select_in(spw), .ids_loaded_in(ldd),
        .cfg_vendor_id_in(vid), .cfg_product_id_in(pid), .cfg_device_id_in(did), .req_valid_in(rv),
        .req_sel_in(sel), .req_len_in(len), .req_ready_out(rdy), .byte_valid_out(bv),
        .byte_data_out(bd), .byte_last_out(bl), .byte_ready_in(br));
    fhdr_host_model fhdr_host_model_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .stall_in(stall),
        .byte_valid_in(bv), .byte_data_in(bd), .byte_last_in(bl), .byte_ready_out(br));
    // ----------------------------------------
    // Clock, hang guard and shared tasks
    // ----------------------------------------
    initial forever #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic check(string what, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // Request held until taken; sampling at negedge avoids racing the edge
    task automatic fetch(string what, logic [1:0] s, logic [7:0] n);
        int base;
        int k;
        base = fhdr_host_model_i.rx_q.size();
        @(posedge ref_clk_in);
        rv <= 1'b1;
        sel <= s;
        len <= n;
        k = 0;
        do @(negedge ref_clk_in); while (rdy !== 1'b1 && ++k < 50);
        @(posedge ref_clk_in);
        rv <= 1'b0;
        k = 0;
        while (fhdr_host_model_i.rx_q.size() < base + exp_q.size() && k++ < 400) @(posedge ref_clk_in);
        repeat (6) @(posedge ref_clk_in);
        check({what, " count"}, 8'(exp_q.size()), 8'(fhdr_host_model_i.rx_q.size() - base));
        check({what, " last"}, 8'(exp_q.size()), 8'(fhdr_host_model_i.last_seen - base));
        for (int i = 0; i < exp_q.size() && base + i < fhdr_host_model_i.rx_q.size(); i++)
            check(what, exp_q[i], fhdr_host_model_i.rx_q[base + i]);
        $display("test %s done", what);
    endtask : fetch
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_device();
        logic [15:0] v, p, d;
        for (int i = 0; i < 2; i++) begin
            str <= 1'(i);
            ldd <= 1'(i);
            v = i ? vid : fhdr_pkg::DEF_VENDOR_ID;
            p = i ? pid : fhdr_pkg::DEF_PRODUCT_ID;
            d = i ? did : fhdr_pkg::DEF_DEVICE_ID;
            exp_q = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h00, 8'h40, v[7:0], v[15:8], p[7:0],
                p[15:8], d[7:0], d[15:8], i ? 8'h01 : 8'h00, i ? 8'h02 : 8'h00, i ? 8'h03 : 8'h00, 8'h01};
            fetch("device", 2'h0, 8'h00);
        end
        exp_q = '{8'h12, 8'h01, 8'h00};
        fetch("short device", 2'h0, 8'h03);
    endtask : t_device
    task automatic t_others();
        stall <= 1'b1;
        exp_q = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF};
        fetch("endpoint", 2'h2, 8'h00);
        stall <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            mtt <= 1'(i);
            spw <= 1'(i);
            exp_q = '{8'h0A, 8'h06, 8'h00, 8'h02, 8'h09, 8'h00, i ? 8'h02 : 8'h01, 8'h40, 8'h01, 8'h00};
            fetch("qualifier", 2'h1, 8'h00);
            exp_q = '{i ? 8'hE0 : 8'hA0};
            fetch("attribute", 2'h3, 8'h00);
        end
    endtask : t_others
    task automatic t_fs_off();
        int base;
        base = fhdr_host_model_i.rx_q.size();
        fs <= 1'b0;
        rv <= 1'b1;
        repeat (8) @(negedge ref_clk_in);
        check("ready in other mode", 8'h00, {7'h00, rdy});
        check("bytes in other mode", 8'h00, 8'(fhdr_host_model_i.rx_q.size() - base));
        @(posedge ref_clk_in);
        rv <= 1'b0;
        fs <= 1'b1;
        $display("test fs_off done");
    endtask : t_fs_off
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_device();
        t_others();
        t_fs_off();
        tally_and_finish();
    end
endmodule : tb_top
